// ---- src/fpm_map.svh ----
// Constants for the power-mode and page-size command block
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

`define FPM_CLK_NS          25
`define FPM_CYC_MAX(t)      (((t) / `FPM_CLK_NS) < 1 ? 1 : ((t) / `FPM_CLK_NS))
`define FPM_CYC_MIN(t)      (((t) + `FPM_CLK_NS - 1) / `FPM_CLK_NS)

`define FPM_DPD_ENTRY_NS    3000
`define FPM_DPD_EXIT_NS     35000
`define FPM_UDPD_ENTRY_NS   3000
`define FPM_UDPD_EXIT_NS    100000
`define FPM_CS_LOW_EXIT_NS  20000
`define FPM_PAGE_PROG_NS    10000000

`define FPM_OP_DPD          8'hb9
`define FPM_OP_RESUME       8'hab
`define FPM_OP_UDPD         8'h79
`define FPM_OP_CFG_B1       8'h3d
`define FPM_OP_CFG_B2       8'h2a
`define FPM_OP_CFG_B3       8'h80
`define FPM_OP_CFG_512      8'ha6
`define FPM_OP_CFG_528      8'ha7

`define FPM_PAGE_BIN        10'h200
`define FPM_PAGE_EXTRA      10'h010
`define FPM_SWITCH_LIMIT    14'h2710
`define FPM_SHIP_528        1'b1
`define FPM_TIMER_W         24

`endif

// ---- src/fpm_pkg.sv ----
// Types shared by both ends of the power-mode and page-size link
package fpm_pkg;
  typedef enum logic [2:0] {
    FPM_CMD_NONE = 3'h0,
    FPM_CMD_DPD  = 3'h1,
    FPM_CMD_RES  = 3'h2,
    FPM_CMD_UDPD = 3'h3,
    FPM_CMD_P512 = 3'h4,
    FPM_CMD_P528 = 3'h5
  } fpm_cmd_t;

  typedef enum logic [2:0] {
    FPM_ST_STANDBY    = 3'b000,
    FPM_ST_DPD_ENTER  = 3'b001,
    FPM_ST_DPD        = 3'b011,
    FPM_ST_DPD_EXIT   = 3'b010,
    FPM_ST_UDPD_ENTER = 3'b110,
    FPM_ST_UDPD       = 3'b111,
    FPM_ST_UDPD_EXIT  = 3'b101,
    FPM_ST_PROGRAM    = 3'b100
  } fpm_state_t;

  typedef enum logic [2:0] {
    FPM_OP_DPD  = 3'h0,
    FPM_OP_RES  = 3'h1,
    FPM_OP_UDPD = 3'h2,
    FPM_OP_WAKE = 3'h3,
    FPM_OP_P512 = 3'h4,
    FPM_OP_P528 = 3'h5
  } fpm_op_t;

  typedef enum logic [2:0] {
    FPM_H_IDLE  = 3'b000,
    FPM_H_LEAD  = 3'b001,
    FPM_H_SHIFT = 3'b011,
    FPM_H_TAIL  = 3'b010,
    FPM_H_WAIT  = 3'b110,
    FPM_H_HOLD  = 3'b111
  } fpm_hstate_t;
endpackage : fpm_pkg

// ---- src/fpm_link_if.sv ----
// Serial link between the host controller and the flash command block
`timescale 1ns/100ps
interface fpm_link_if;
  logic cs_n;
  logic sck;
  logic mosi;

  modport host (
    output cs_n,
    output sck,
    output mosi
  );

  modport dev (
    input cs_n,
    input sck,
    input mosi
  );
endinterface : fpm_link_if

// ---- src/fpm_dev.sv ----
// Flash-side power-mode and page-size command logic
`timescale 1ns/100ps
`include "fpm_map.svh"
module fpm_dev import fpm_pkg::*; #(
  parameter int P_DPD_ENTRY_CYC  = `FPM_CYC_MAX(`FPM_DPD_ENTRY_NS),
  parameter int P_DPD_EXIT_CYC   = `FPM_CYC_MAX(`FPM_DPD_EXIT_NS),
  parameter int P_UDPD_ENTRY_CYC = `FPM_CYC_MAX(`FPM_UDPD_ENTRY_NS),
  parameter int P_UDPD_EXIT_CYC  = `FPM_CYC_MAX(`FPM_UDPD_EXIT_NS),
  parameter int P_CS_LOW_CYC     = `FPM_CYC_MIN(`FPM_CS_LOW_EXIT_NS),
  parameter int P_PROG_CYC       = `FPM_CYC_MAX(`FPM_PAGE_PROG_NS),
  parameter bit P_SHIP_528       = `FPM_SHIP_528
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_array_busy,
  fpm_link_if.dev         link,
  output fpm_state_t      o_state,
  output logic            o_busy,
  output logic            o_page_528,
  output logic [9:0]      o_page_bytes,
  output logic            o_buf_clear
);
  localparam int TW = `FPM_TIMER_W;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: bit counting and byte decode
  logic           fresh_reg;
  logic           tog_reg;
  logic [2:0]     phase_reg;
  logic [2:0]     nbytes_reg;
  logic [6:0]     shift_reg;
  logic           seq_reg;
  fpm_cmd_t       cmd_reg;
  logic [7:0]     byte_now;

  assign byte_now = {shift_reg, link.mosi};

  // Marks the first clock of each frame; set while chip select is high
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_ff @(posedge link.sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_reg    <= 1'b0;
      phase_reg  <= 3'h0;
      nbytes_reg <= 3'h0;
      shift_reg  <= 7'h00;
    end else if (fresh_reg) begin
      tog_reg    <= ~tog_reg;
      phase_reg  <= 3'h1;
      nbytes_reg <= 3'h0;
      shift_reg  <= {6'h00, link.mosi};
    end else begin
      phase_reg <= phase_reg + 3'h1;
      shift_reg <= byte_now[6:0];
      if (phase_reg == 3'h7 && nbytes_reg != 3'h7) begin
        nbytes_reg <= nbytes_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge link.sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_reg <= FPM_CMD_NONE;
      seq_reg <= 1'b0;
    end else if (fresh_reg) begin
      cmd_reg <= FPM_CMD_NONE;
      seq_reg <= 1'b0;
    end else if (phase_reg == 3'h7) begin
      unique case (nbytes_reg)
        3'h0: begin
          unique case (byte_now)
            `FPM_OP_DPD:    cmd_reg <= FPM_CMD_DPD;
            `FPM_OP_RESUME: cmd_reg <= FPM_CMD_RES;
            `FPM_OP_UDPD:   cmd_reg <= FPM_CMD_UDPD;
            default:        cmd_reg <= FPM_CMD_NONE;
          endcase
          seq_reg <= (byte_now == `FPM_OP_CFG_B1);
        end
        3'h1: seq_reg <= seq_reg && (byte_now == `FPM_OP_CFG_B2);
        3'h2: seq_reg <= seq_reg && (byte_now == `FPM_OP_CFG_B3);
        3'h3: begin
          if (seq_reg && byte_now == `FPM_OP_CFG_512) begin
            cmd_reg <= FPM_CMD_P512;
          end else if (seq_reg && byte_now == `FPM_OP_CFG_528) begin
            cmd_reg <= FPM_CMD_P528;
          end
        end
        default: seq_reg <= seq_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core domain: frame end detection
  logic           cs_m_reg, cs_s_reg, cs_d_reg;
  logic           tog_m_reg, tog_s_reg, tog_seen_reg;
  logic           frame_ok_reg;
  logic [TW-1:0]  low_cnt_reg;
  logic           cs_rise, cs_fall, frame_bits, frame_aligned;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_m_reg  <= 1'b1;
      cs_s_reg  <= 1'b1;
      cs_d_reg  <= 1'b1;
      tog_m_reg <= 1'b0;
      tog_s_reg <= 1'b0;
    end else begin
      cs_m_reg  <= link.cs_n;
      cs_s_reg  <= cs_m_reg;
      cs_d_reg  <= cs_s_reg;
      tog_m_reg <= tog_reg;
      tog_s_reg <= tog_m_reg;
    end
  end

  assign cs_rise    = cs_s_reg & ~cs_d_reg;
  assign cs_fall    = ~cs_s_reg & cs_d_reg;
  assign frame_bits = (tog_s_reg != tog_seen_reg);
  // Link clock is stopped once chip select is high, so these are stable
  // whole bytes only
  assign frame_aligned = frame_bits && (phase_reg == 3'h0) && (nbytes_reg != 3'h0);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_seen_reg <= 1'b0;
    end else if (cs_rise) begin
      tog_seen_reg <= tog_s_reg;
    end
  end

  // Chip select low time for the ultra-deep exit pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_reg <= '0;
    end else if (cs_fall) begin
      low_cnt_reg <= '0;
    end else if (!cs_s_reg && low_cnt_reg != {TW{1'b1}}) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  // frames started outside a settled state are dropped
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_ok_reg <= 1'b0;
    end else if (cs_fall) begin
      frame_ok_reg <= (o_state == FPM_ST_STANDBY) || (o_state == FPM_ST_DPD) ||
                      (o_state == FPM_ST_UDPD);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core domain: power state machine
  fpm_state_t     state_next;
  logic [TW-1:0]  timer_reg;
  logic [TW-1:0]  timer_next;
  logic           pend_528_reg;
  logic           take;

  assign take = cs_rise && frame_ok_reg && frame_aligned;

  always_comb begin
    state_next = o_state;
    timer_next = (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
    unique case (o_state)
      FPM_ST_STANDBY: begin
        // entry refused during an internal cycle
        if (take && !i_array_busy) begin
          unique case (cmd_reg)
            FPM_CMD_DPD: begin
              state_next = FPM_ST_DPD_ENTER;
              timer_next = TW'(P_DPD_ENTRY_CYC - 1);
            end
            FPM_CMD_UDPD: begin
              state_next = FPM_ST_UDPD_ENTER;
              timer_next = TW'(P_UDPD_ENTRY_CYC - 1);
            end
            FPM_CMD_P512, FPM_CMD_P528: begin
              state_next = FPM_ST_PROGRAM;
              timer_next = TW'(P_PROG_CYC - 1);
            end
            default: state_next = FPM_ST_STANDBY;
          endcase
        end
      end
      FPM_ST_DPD_ENTER:
        if (timer_reg == '0) state_next = FPM_ST_DPD;
      FPM_ST_DPD: begin
        if (take && cmd_reg == FPM_CMD_RES) begin
          state_next = FPM_ST_DPD_EXIT;
          timer_next = TW'(P_DPD_EXIT_CYC - 1);
        end
      end
      FPM_ST_DPD_EXIT:
        if (timer_reg == '0) state_next = FPM_ST_STANDBY;
      FPM_ST_UDPD_ENTER:
        if (timer_reg == '0) state_next = FPM_ST_UDPD;
      FPM_ST_UDPD: begin
        if (cs_rise && frame_ok_reg && low_cnt_reg >= TW'(P_CS_LOW_CYC - 1)) begin
          state_next = FPM_ST_UDPD_EXIT;
          timer_next = TW'(P_UDPD_EXIT_CYC - 1);
        end
      end
      FPM_ST_UDPD_EXIT:
        if (timer_reg == '0) state_next = FPM_ST_STANDBY;
      FPM_ST_PROGRAM:
        if (timer_reg == '0) state_next = FPM_ST_STANDBY;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state   <= FPM_ST_STANDBY;
      timer_reg <= '0;
      o_busy    <= 1'b0;
    end else begin
      o_state   <= state_next;
      timer_reg <= timer_next;
      o_busy    <= (state_next == FPM_ST_PROGRAM);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_buf_clear <= 1'b0;
    end else begin
      o_buf_clear <= (o_state == FPM_ST_STANDBY) && (state_next == FPM_ST_UDPD_ENTER);
    end
  end

  // Reset stands in for the nonvolatile value; real storage keeps it
  // shipped default
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_528_reg <= P_SHIP_528;
      o_page_528   <= P_SHIP_528;
      o_page_bytes <= P_SHIP_528 ? `FPM_PAGE_BIN + `FPM_PAGE_EXTRA : `FPM_PAGE_BIN;
    end else begin
      if (o_state == FPM_ST_STANDBY && state_next == FPM_ST_PROGRAM) begin
        pend_528_reg <= (cmd_reg == FPM_CMD_P528);
      end
      if (o_state == FPM_ST_PROGRAM && state_next == FPM_ST_STANDBY) begin
        o_page_528   <= pend_528_reg;
        o_page_bytes <= pend_528_reg ? `FPM_PAGE_BIN + `FPM_PAGE_EXTRA : `FPM_PAGE_BIN;
      end
    end
  end
endmodule : fpm_dev

// ---- src/fpm_host.sv ----
// Host-side sequencer that issues power-mode and page-size frames
`timescale 1ns/100ps
`include "fpm_map.svh"
module fpm_host import fpm_pkg::*; #(
  parameter int P_HALF_CYC       = 2,
  parameter int P_MARGIN_CYC     = 8,
  parameter int P_DPD_ENTRY_CYC  = `FPM_CYC_MAX(`FPM_DPD_ENTRY_NS),
  parameter int P_DPD_EXIT_CYC   = `FPM_CYC_MAX(`FPM_DPD_EXIT_NS),
  parameter int P_UDPD_ENTRY_CYC = `FPM_CYC_MAX(`FPM_UDPD_ENTRY_NS),
  parameter int P_UDPD_EXIT_CYC  = `FPM_CYC_MAX(`FPM_UDPD_EXIT_NS),
  parameter int P_CS_LOW_CYC     = `FPM_CYC_MIN(`FPM_CS_LOW_EXIT_NS),
  parameter int P_PROG_CYC       = `FPM_CYC_MAX(`FPM_PAGE_PROG_NS)
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  fpm_op_t         i_op,
  input  wire logic       i_short,
  fpm_link_if.host        link,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_limit
);
  localparam int TW = `FPM_TIMER_W;

  fpm_hstate_t    st_reg;
  logic [TW-1:0]  cnt_reg;
  logic [TW-1:0]  wait_reg;
  logic [31:0]    sh_reg;
  logic [5:0]     bits_reg;
  logic           cs_n_reg, sck_reg, mosi_reg;
  logic [13:0]    switches_reg;
  logic           page_op;

  assign link.cs_n = cs_n_reg;
  assign link.sck  = sck_reg;
  assign link.mosi = mosi_reg;
  assign page_op   = (i_op == FPM_OP_P512) || (i_op == FPM_OP_P528);

  // Waits cover the device's longest delay plus its synchroniser latency
  function automatic logic [TW-1:0] fpm_wait(input fpm_op_t op);
    unique case (op)
      FPM_OP_DPD:  fpm_wait = TW'(P_DPD_ENTRY_CYC + P_MARGIN_CYC);
      FPM_OP_RES:  fpm_wait = TW'(P_DPD_EXIT_CYC + P_MARGIN_CYC);
      FPM_OP_UDPD: fpm_wait = TW'(P_UDPD_ENTRY_CYC + P_MARGIN_CYC);
      FPM_OP_WAKE: fpm_wait = TW'(P_UDPD_EXIT_CYC + P_MARGIN_CYC);
      default:     fpm_wait = TW'(P_PROG_CYC + P_MARGIN_CYC);
    endcase
  endfunction : fpm_wait

  function automatic logic [31:0] fpm_frame(input fpm_op_t op);
    unique case (op)
      FPM_OP_DPD:  fpm_frame = {`FPM_OP_DPD, 24'h000000};
      FPM_OP_RES:  fpm_frame = {`FPM_OP_RESUME, 24'h000000};
      FPM_OP_UDPD: fpm_frame = {`FPM_OP_UDPD, 24'h000000};
      FPM_OP_P512: fpm_frame = {`FPM_OP_CFG_B1, `FPM_OP_CFG_B2, `FPM_OP_CFG_B3, `FPM_OP_CFG_512};
      default:     fpm_frame = {`FPM_OP_CFG_B1, `FPM_OP_CFG_B2, `FPM_OP_CFG_B3, `FPM_OP_CFG_528};
    endcase
  endfunction : fpm_frame

  assign o_limit = (switches_reg >= `FPM_SWITCH_LIMIT);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      switches_reg <= 14'h0000;
    end else if (st_reg == FPM_H_IDLE && i_start && page_op && !o_limit) begin
      switches_reg <= switches_reg + 14'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg   <= FPM_H_IDLE;
      cnt_reg  <= '0;
      wait_reg <= '0;
      sh_reg   <= 32'h00000000;
      bits_reg <= 6'h00;
      cs_n_reg <= 1'b1;
      sck_reg  <= 1'b0;
      mosi_reg <= 1'b0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (st_reg)
        FPM_H_IDLE: begin
          if (i_start && !(page_op && o_limit)) begin
            o_busy   <= 1'b1;
            cs_n_reg <= 1'b0;
            wait_reg <= fpm_wait(i_op);
            sh_reg   <= fpm_frame(i_op);
            bits_reg <= (page_op ? 6'h20 : 6'h08) - {5'h00, i_short};
            if (i_op == FPM_OP_WAKE) begin
              st_reg  <= FPM_H_HOLD;
              cnt_reg <= TW'(P_CS_LOW_CYC + P_MARGIN_CYC);
            end else begin
              st_reg  <= FPM_H_LEAD;
              cnt_reg <= TW'(P_HALF_CYC);
            end
          end
        end
        FPM_H_LEAD: begin
          mosi_reg <= sh_reg[31];
          if (cnt_reg == TW'(1)) begin
            st_reg  <= FPM_H_SHIFT;
            cnt_reg <= TW'(P_HALF_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        FPM_H_SHIFT: begin
          if (cnt_reg != TW'(1)) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            cnt_reg <= TW'(P_HALF_CYC);
            sck_reg <= ~sck_reg;
            if (sck_reg) begin
              sh_reg   <= {sh_reg[30:0], 1'b0};
              mosi_reg <= sh_reg[30];
              bits_reg <= bits_reg - 6'h01;
              if (bits_reg == 6'h01) begin
                st_reg <= FPM_H_TAIL;
              end
            end
          end
        end
        FPM_H_TAIL, FPM_H_HOLD: begin
          if (cnt_reg == TW'(1)) begin
            cs_n_reg <= 1'b1;
            mosi_reg <= 1'b0;
            st_reg   <= FPM_H_WAIT;
            cnt_reg  <= wait_reg;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        FPM_H_WAIT: begin
          // reissue is left to the user
          if (cnt_reg == TW'(1)) begin
            st_reg <= FPM_H_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: st_reg <= FPM_H_IDLE;
      endcase
    end
  end
endmodule : fpm_host

// ---- verif/fpm_link_asserts.sv ----
// Property checker watching the link and the flash-side outputs
`timescale 1ns/100ps
module fpm_link_asserts import fpm_pkg::*; #(
  parameter int P_DPD_ENTRY_CYC  = 4,
  parameter int P_DPD_EXIT_CYC   = 4,
  parameter int P_UDPD_ENTRY_CYC = 4,
  parameter int P_UDPD_EXIT_CYC  = 4
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_array_busy,
  input  wire logic       cs_n,
  input  fpm_state_t      o_state,
  input  wire logic       o_busy,
  input  wire logic       o_page_528,
  input  wire logic [9:0] o_page_bytes,
  input  wire logic       o_buf_clear
);
  // One spare cycle for the settle edge
  localparam int DIN  = P_DPD_ENTRY_CYC + 1;
  localparam int DOUT = P_DPD_EXIT_CYC + 1;
  localparam int UIN  = P_UDPD_ENTRY_CYC + 1;
  localparam int UOUT = P_UDPD_EXIT_CYC + 1;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_dpd_in;
    $rose(o_state == FPM_ST_DPD_ENTER);
  endsequence
  sequence s_dpd_out;
    $rose(o_state == FPM_ST_DPD_EXIT);
  endsequence
  sequence s_udpd_in;
    $rose(o_state == FPM_ST_UDPD_ENTER);
  endsequence
  sequence s_udpd_out;
    $rose(o_state == FPM_ST_UDPD_EXIT);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_DPD_IN: assert property (s_dpd_in |-> ##[1:DIN] o_state == FPM_ST_DPD)
    else $error("deep power-down entry overran");
  AST_DPD_OUT: assert property (s_dpd_out |-> ##[1:DOUT] o_state == FPM_ST_STANDBY)
    else $error("deep power-down exit overran");
  AST_UDPD_IN: assert property (s_udpd_in |-> ##[1:UIN] o_state == FPM_ST_UDPD)
    else $error("ultra-deep entry overran");
  AST_UDPD_OUT: assert property (s_udpd_out |-> ##[1:UOUT] o_state == FPM_ST_STANDBY)
    else $error("ultra-deep exit overran");
  AST_DPD_HOLD: assert property (o_state == FPM_ST_DPD |=> o_state inside {FPM_ST_DPD, FPM_ST_DPD_EXIT})
    else $error("deep power-down left by a wrong command");
  AST_UDPD_HOLD: assert property (o_state == FPM_ST_UDPD |=> o_state inside {FPM_ST_UDPD, FPM_ST_UDPD_EXIT})
    else $error("ultra-deep left by a command");
  AST_EXIT_DEAF: assert property (o_state == FPM_ST_UDPD_EXIT |=> o_state inside {FPM_ST_UDPD_EXIT, FPM_ST_STANDBY})
    else $error("frame taken during ultra-deep exit");
  AST_BUF_CLR: assert property (o_buf_clear |-> o_state == FPM_ST_UDPD_ENTER && $past(o_state) == FPM_ST_STANDBY)
    else $error("buffer discard pulse misplaced");
  AST_BUSY_PROG: assert property (o_busy == (o_state == FPM_ST_PROGRAM))
    else $error("busy flag does not match programming");
  AST_PAGE_SIZE: assert property (o_page_bytes == (o_page_528 ? 10'h210 : 10'h200))
    else $error("page byte count does not match setting");
  AST_PAGE_COMMIT: assert property ($changed(o_page_528) |-> $past(o_state) == FPM_ST_PROGRAM)
    else $error("page setting changed outside programming end");
  AST_ARRAY_BUSY: assert property (o_state == FPM_ST_STANDBY && i_array_busy && $past(i_array_busy)
                                   |=> o_state == FPM_ST_STANDBY)
    else $error("entry taken while array busy");
  AST_IDLE: assert property (cs_n [*6] ##0 o_state == FPM_ST_STANDBY |=> o_state == FPM_ST_STANDBY)
    else $error("standby left while chip select idle");
endmodule : fpm_link_asserts

// ---- verif/tb_flash_power_mode_page_size_ctrl.sv ----
// Self-checking bench joining the host sequencer to the flash command block
`timescale 1ns/100ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module tb_flash_power_mode_page_size_ctrl import fpm_pkg::*;;
  // Exit pulse outlasts a one-byte frame, so a lone opcode cannot wake ultra-deep
  localparam int C_DIN = 12, C_DOUT = 20, C_UIN = 12, C_UOUT = 24, C_CSL = 48, C_PROG = 40;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic        h_start    = 1'b0;
  logic        h_short    = 1'b0;
  logic        a_busy     = 1'b0;
  fpm_op_t     h_op       = FPM_OP_DPD;
  logic        h_busy, h_done, h_limit, d_busy, d_p528, d_clr;
  fpm_state_t  d_state;
  logic [9:0]  d_bytes;
  logic [31:0] wire_sh;
  int          wire_bits, miscompares = 0, check_count = 0;
  logic        busy_seen, clr_seen;

  always #12.5 i_core_clk = ~i_core_clk;

  ////////////////////////////////////////////////////////////////////////////
  fpm_link_if fpm_link_if_i ();
  fpm_host #(.P_DPD_ENTRY_CYC(C_DIN), .P_DPD_EXIT_CYC(C_DOUT), .P_UDPD_ENTRY_CYC(C_UIN),
    .P_UDPD_EXIT_CYC(C_UOUT), .P_CS_LOW_CYC(C_CSL), .P_PROG_CYC(C_PROG)) fpm_host_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(h_start), .i_op(h_op),
    .i_short(h_short), .link(fpm_link_if_i.host), .o_busy(h_busy), .o_done(h_done), .o_limit(h_limit));
  fpm_dev #(.P_DPD_ENTRY_CYC(C_DIN), .P_DPD_EXIT_CYC(C_DOUT), .P_UDPD_ENTRY_CYC(C_UIN),
    .P_UDPD_EXIT_CYC(C_UOUT), .P_CS_LOW_CYC(C_CSL), .P_PROG_CYC(C_PROG)) fpm_dev_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_array_busy(a_busy), .link(fpm_link_if_i.dev),
    .o_state(d_state), .o_busy(d_busy), .o_page_528(d_p528), .o_page_bytes(d_bytes), .o_buf_clear(d_clr));
  fpm_link_asserts #(.P_DPD_ENTRY_CYC(C_DIN), .P_DPD_EXIT_CYC(C_DOUT), .P_UDPD_ENTRY_CYC(C_UIN),
    .P_UDPD_EXIT_CYC(C_UOUT)) fpm_link_asserts_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_array_busy(a_busy), .cs_n(fpm_link_if_i.cs_n),
    .o_state(d_state), .o_busy(d_busy), .o_page_528(d_p528), .o_page_bytes(d_bytes), .o_buf_clear(d_clr));

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags catch one-cycle pulses between checks
  always @(posedge i_core_clk) begin
    if (d_busy === 1'b1) busy_seen = 1'b1;
    if (d_clr === 1'b1) clr_seen = 1'b1;
  end
  // Wire snoop: mode 0, sample on rising serial clock
  always @(negedge fpm_link_if_i.cs_n) wire_bits = 0;
  always @(posedge fpm_link_if_i.sck) if (fpm_link_if_i.cs_n === 1'b0) begin
    wire_sh = {wire_sh[30:0], fpm_link_if_i.mosi};
    wire_bits++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic run_op(input fpm_op_t op, input logic sh);
    int n;
    n = 0;
    busy_seen = 1'b0;
    clr_seen = 1'b0;
    @(negedge i_core_clk);
    h_op = op;
    h_short = sh;
    h_start = 1'b1;
    @(negedge i_core_clk);
    h_start = 1'b0;
    h_short = 1'b0;
    `CHK("host busy", 1'b1, h_busy)
    while (h_done !== 1'b1 && n < 4000) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n >= 4000) begin
      miscompares++;
      conclude();
    end
    `CHK("host idle", 1'b0, h_busy)
    repeat (2) @(negedge i_core_clk);
  endtask : run_op

  task automatic t_reset;
    `CHK("state", FPM_ST_STANDBY, d_state)
    `CHK("page_528", 1'b1, d_p528)
    `CHK("page_bytes", 10'h210, d_bytes)
    `CHK("cs_n idle", 1'b1, fpm_link_if_i.cs_n)
    $display("t_reset finished");
  endtask : t_reset

  task automatic t_dpd;
    run_op(FPM_OP_DPD, 1'b0);
    `CHK("dpd opcode", 8'hb9, wire_sh[7:0])
    `CHK("dpd bits", 8, wire_bits)
    `CHK("dpd state", FPM_ST_DPD, d_state)
    run_op(FPM_OP_UDPD, 1'b0);
    `CHK("dpd ignores udpd", FPM_ST_DPD, d_state)
    run_op(FPM_OP_RES, 1'b1);
    `CHK("short resume", FPM_ST_DPD, d_state)
    run_op(FPM_OP_RES, 1'b0);
    `CHK("resume opcode", 8'hab, wire_sh[7:0])
    `CHK("resumed", FPM_ST_STANDBY, d_state)
    $display("t_dpd finished");
  endtask : t_dpd

  task automatic t_abort;
    run_op(FPM_OP_DPD, 1'b1);
    `CHK("short dpd bits", 7, wire_bits)
    `CHK("short dpd", FPM_ST_STANDBY, d_state)
    run_op(FPM_OP_UDPD, 1'b1);
    `CHK("short udpd", FPM_ST_STANDBY, d_state)
    `CHK("no discard", 1'b0, clr_seen)
    $display("t_abort finished");
  endtask : t_abort

  task automatic t_array;
    @(negedge i_core_clk);
    a_busy = 1'b1;
    run_op(FPM_OP_DPD, 1'b0);
    `CHK("busy dpd", FPM_ST_STANDBY, d_state)
    run_op(FPM_OP_UDPD, 1'b0);
    `CHK("busy udpd", FPM_ST_STANDBY, d_state)
    run_op(FPM_OP_P512, 1'b0);
    `CHK("busy page", 1'b1, d_p528)
    a_busy = 1'b0;
    run_op(FPM_OP_DPD, 1'b0);
    `CHK("reissued dpd", FPM_ST_DPD, d_state)
    run_op(FPM_OP_RES, 1'b0);
    $display("t_array finished");
  endtask : t_array

  task automatic t_udpd;
    run_op(FPM_OP_UDPD, 1'b0);
    `CHK("udpd opcode", 8'h79, wire_sh[7:0])
    `CHK("udpd state", FPM_ST_UDPD, d_state)
    `CHK("discard pulse", 1'b1, clr_seen)
    run_op(FPM_OP_RES, 1'b0);
    `CHK("udpd ignores resume", FPM_ST_UDPD, d_state)
    run_op(FPM_OP_WAKE, 1'b0);
    `CHK("woken", FPM_ST_STANDBY, d_state)
    $display("t_udpd finished");
  endtask : t_udpd

  task automatic t_page;
    run_op(FPM_OP_P512, 1'b0);
    `CHK("p512 frame", 32'h3d2a80a6, wire_sh)
    `CHK("p512 busy", 1'b1, busy_seen)
    `CHK("p512 set", 1'b0, d_p528)
    `CHK("p512 bytes", 10'h200, d_bytes)
    run_op(FPM_OP_P528, 1'b0);
    `CHK("p528 frame", 32'h3d2a80a7, wire_sh)
    `CHK("p528 bytes", 10'h210, d_bytes)
    run_op(FPM_OP_P512, 1'b0);
    `CHK("back to 512", 1'b0, d_p528)
    `CHK("limit clear", 1'b0, h_limit)
    i_rst_n = 1'b0;
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_core_clk);
    `CHK("reset state", FPM_ST_STANDBY, d_state)
    `CHK("reset page", 1'b1, d_p528)
    $display("t_page finished");
  endtask : t_page

  initial begin
    repeat (10) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_core_clk);
    t_reset();
    t_dpd();
    t_abort();
    t_array();
    t_udpd();
    t_page();
    conclude();
  end
endmodule : tb_flash_power_mode_page_size_ctrl
